// file: inc/lfms_pkg.sv
package lfms_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_SCAN   = 8'h08;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_DECERR = 2'b11;
  localparam int         PIN_COUNT   = 4;
  // control field positions
  localparam int CTRL_FM_LSB    = 0;
  localparam int CTRL_LM_LSB    = 4;
  localparam int CTRL_TX_ZERO_SUPPRESS_DISABLE_BIT  = 8;
  localparam int CTRL_RX_ZERO_SUPPRESS_DISABLE_BIT  = 9;
  localparam int CTRL_TX_LINE_PIN_ENABLE_BIT  = 10;
  localparam int CTRL_CLADT_BIT = 11;
  localparam int CTRL_DENO_BIT  = 12;
  localparam int SCAN_OUT_LSB   = 0;
  localparam int SCAN_OE_LSB    = 4;
  localparam int STAT_PIN_LSB   = 16;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] SCAN_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_MASK  = 32'h0000_1F77;
  localparam logic [31:0] SCAN_MASK  = 32'h0000_00FF;
  // frame-mode codes
  typedef enum logic [2:0] {
    LFMS_FM_DS3_CBIT  = 3'b000,
    LFMS_FM_DS3_M23   = 3'b001,
    LFMS_FM_E3_G751   = 3'b010,
    LFMS_FM_E3_G832   = 3'b011,
    LFMS_FM_DS3_UNFR  = 3'b100,
    LFMS_FM_RSVD_5    = 3'b101,
    LFMS_FM_E3_UNFR   = 3'b110,
    LFMS_FM_RSVD_7    = 3'b111
  } lfms_fm_type;
  localparam logic [2:0] LM_RAIL = 3'b000;
  // decoded operating mode
  typedef struct packed {
    logic       framer_on;   // framing overhead processed
    logic [1:0] fmt;         // 0 cbit 1 m23 2 g751 3 g832
    logic       unframed;
    logic       is_e3;       // line rate / adapter rate
    logic       clock_rate_adapter_tx;     // adapter drives transmit clock
    logic       hdb3;        // 1 hdb3, 0 b3zs
    logic       tx_ami;
    logic       rx_ami;
    logic       rails_on;
    logic       unipolar;
    logic       liu_on;
    logic       reserved;
    logic       cfg_err;
  } lfms_mode_type;
  localparam int MODE_W = $bits(lfms_mode_type);
endpackage

// file: src/lfms_top.sv
// Contract
// RL1 - frame code 000 cbit, 001 m23, 010 g751, 011 g832 framing
// RL2 - frame code 100 unframed ds3, 110 unframed e3, no overhead
// RL3 - unframed: adapter rate follows frame code when it sources transmit clock
// RL4 - unframed rail mode: b3zs or hdb3 chosen by frame code
// RL5 - line code 000: internal interface off, rails on, zs bits pick ami
// RL6 - line code 1xx: unipolar, zs bits ignored, line enable needed
// RL7 - unipolar works unframed, adapter rate follows frame code
// RL8 - far end drives negative rail or violation on negative input
// RL9 - transmit marker pin is frame start or data enable by option
// RL10 - scan mode makes every digital pin bidirectional; here only the four line pins, marker pin stays output
// RL11 - unused features held in reset, registers stay accessible
// RL12 - frame codes 101 and 111 reserved, flagged and idle
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none
module lfms_top (
  input  wire logic                 aclk,            // 50 MHz clock
  input  wire logic                 aresetn,         // sync reset, low
  input  wire logic                 ce,              // clock enable
  input  wire logic [7:0]           s_axi_awaddr,    // write address
  input  wire logic                 s_axi_awvalid,   // write addr valid
  output logic                      s_axi_awready,   // write addr ready
  input  wire logic [31:0]          s_axi_wdata,     // write data
  input  wire logic [3:0]           s_axi_wstrb,     // byte enables
  input  wire logic                 s_axi_wvalid,    // write data valid
  output logic                      s_axi_wready,    // write data ready
  output logic [1:0]                s_axi_bresp,     // write response
  output logic                      s_axi_bvalid,    // write resp valid
  input  wire logic                 s_axi_bready,    // write resp ready
  input  wire logic [7:0]           s_axi_araddr,    // read address
  input  wire logic                 s_axi_arvalid,   // read addr valid
  output logic                      s_axi_arready,   // read addr ready
  output logic [31:0]               s_axi_rdata,     // read data
  output logic [1:0]                s_axi_rresp,     // read response
  output logic                      s_axi_rvalid,    // read valid
  input  wire logic                 s_axi_rready,    // read ready
  input  wire logic                 scan_mode_pin,   // boundary scan active
  input  wire logic [3:0]           line_pin_in,     // pad levels
  output logic [3:0]                line_pin_out,    // pad drive values
  output logic [3:0]                line_pin_oe,     // pad drive enables
  input  wire logic                 tx_data_in,      // framer positive/data
  input  wire logic                 tx_neg_in,       // framer negative rail
  input  wire logic                 tx_sof_in,       // framer frame start
  input  wire logic                 tx_den_in,       // framer data enable
  output logic                      tx_frame_marker_or_data_enable, // marker pin
  output logic                      rx_data_out,     // receive data/pos rail
  output logic                      rx_neg_rail_out, // receive neg rail
  output logic                      rx_violation,    // line code violation
  output lfms_pkg::lfms_mode_type   mode             // decoded mode
);
  // pin 0 tx pos/data, 1 tx neg, 2 rx pos/data, 3 rx neg/violation
  logic [31:0] ctrl_reg;
  logic [31:0] scan_reg;
  logic        aw_held_reg;
  logic        w_held_reg;
  logic [7:0]  aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic [4:0]  sync1_reg;
  logic [4:0]  sync2_reg;
  logic [4:0]  sync3_reg;
  logic [4:0]  filt_reg;
  lfms_pkg::lfms_mode_type mode_next;

  // three-stage synchronisers; level accepted once stages two and three agree
  logic [4:0] raw_in;
  assign raw_in = {scan_mode_pin, line_pin_in};
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++)
    begin : g_sync
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
          sync3_reg[gi] <= 1'b0;
          filt_reg[gi]  <= 1'b0;
        end
        else if (ce)
        begin
          sync1_reg[gi] <= raw_in[gi];
          sync2_reg[gi] <= sync1_reg[gi];
          sync3_reg[gi] <= sync2_reg[gi];
          if (sync2_reg[gi] == sync3_reg[gi])
            filt_reg[gi] <= sync3_reg[gi];
        end
      end
    end
  endgenerate
  wire logic       scan_on = filt_reg[4];
  wire logic [3:0] pin_lvl = filt_reg[3:0];

  // mode decode from control fields
  wire logic [2:0] fm_code   = ctrl_reg[lfms_pkg::CTRL_FM_LSB +: 3];
  wire logic [2:0] lm_code   = ctrl_reg[lfms_pkg::CTRL_LM_LSB +: 3];
  wire logic       tx_zero_suppress_disable      = ctrl_reg[lfms_pkg::CTRL_TX_ZERO_SUPPRESS_DISABLE_BIT];
  wire logic       rx_zero_suppress_disable      = ctrl_reg[lfms_pkg::CTRL_RX_ZERO_SUPPRESS_DISABLE_BIT];
  wire logic       tx_line_pin_enable      = ctrl_reg[lfms_pkg::CTRL_TX_LINE_PIN_ENABLE_BIT];
  wire logic       fm_rsvd   = (fm_code == lfms_pkg::LFMS_FM_RSVD_5) ||
                               (fm_code == lfms_pkg::LFMS_FM_RSVD_7); // [RL12]
  wire logic       fm_framed = !fm_code[2];                          // [RL1]
  wire logic       fm_unfr   = fm_code[2] && !fm_rsvd;               // [RL2]
  wire logic       lm_rail   = (lm_code == lfms_pkg::LM_RAIL);       // [RL5]
  wire logic       lm_uni    = lm_code[2];                           // [RL6]
  wire logic       lm_liu    = !lm_rail && !lm_uni;
  // rails or unipolar pins need the line enable; otherwise a config error
  wire logic       pins_ok   = (lm_rail || lm_uni) && tx_line_pin_enable && !fm_rsvd; // [RL5] [RL6]
  // e3 for g751/g832 (bit1 framed) and unframed e3 (110)
  wire logic       fm_e3     = fm_code[1];

  always_comb
  begin
    mode_next           = '0;
    mode_next.reserved  = fm_rsvd;                                   // [RL12]
    mode_next.framer_on = fm_framed && pins_ok;                      // [RL1] [RL11]
    mode_next.fmt       = fm_framed ? fm_code[1:0] : 2'b00;          // [RL1]
    mode_next.unframed  = fm_unfr && pins_ok;                        // [RL2]
    mode_next.is_e3     = fm_e3 && !fm_rsvd;                         // [RL3] [RL7]
    // adapter only sourced in unframed operation; rate set by is_e3
    mode_next.clock_rate_adapter_tx   = fm_unfr && pins_ok &&
                          ctrl_reg[lfms_pkg::CTRL_CLADT_BIT];        // [RL3] [RL7]
    mode_next.hdb3      = fm_e3;                                     // [RL4]
    mode_next.tx_ami    = lm_rail && tx_zero_suppress_disable;                           // [RL5]
    mode_next.rx_ami    = lm_rail && rx_zero_suppress_disable;                           // [RL5]
    mode_next.rails_on  = lm_rail && pins_ok;                        // [RL5]
    mode_next.unipolar  = lm_uni && pins_ok;                         // [RL6] [RL7]
    mode_next.liu_on    = 1'b0;                                      // [RL5] [RL11]
    mode_next.cfg_err   = fm_rsvd || lm_liu || !tx_line_pin_enable;
  end

  // line pin drive: scan overrides everything so pads can be forced and watched
  wire logic       path_on = mode_next.rails_on || mode_next.unipolar;
  wire logic [3:0] norm_out = {2'b00, mode_next.rails_on & tx_neg_in,
                               path_on & tx_data_in};
  wire logic [3:0] norm_oe  = {2'b00, mode_next.rails_on, path_on};
  wire logic [3:0] scan_out = scan_reg[lfms_pkg::SCAN_OUT_LSB +: 4];
  wire logic [3:0] scan_oe  = scan_reg[lfms_pkg::SCAN_OE_LSB +: 4];
  wire logic [3:0] pin_out_next = scan_on ? scan_out : norm_out;    // [RL10]
  wire logic [3:0] pin_oe_next  = scan_on ? scan_oe : norm_oe;      // [RL10]
  // marker pin shows frame start or data enable; idle when neither rail nor unipolar path is on
  wire logic       marker_next = !path_on ? 1'b0 :
                     (ctrl_reg[lfms_pkg::CTRL_DENO_BIT] ? tx_den_in : tx_sof_in); // [RL9]
  // negative input carries the rail or a violation flag by line mode
  wire logic       rx_neg_next = mode_next.rails_on & pin_lvl[3];   // [RL8]
  wire logic       rx_lcv_next = mode_next.unipolar & pin_lvl[3];   // [RL8]
  wire logic       rx_dat_next = path_on & pin_lvl[2];              // [RL11]

  // registered datapath outputs; unused paths sit at zero
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mode            <= '0;
      line_pin_out    <= 4'h0;
      line_pin_oe     <= 4'h0;
      rx_data_out     <= 1'b0;
      rx_neg_rail_out <= 1'b0;
      rx_violation    <= 1'b0;
      tx_frame_marker_or_data_enable <= 1'b0;
    end
    else if (ce)
    begin
      mode            <= mode_next;
      line_pin_out    <= pin_out_next;
      line_pin_oe     <= pin_oe_next;
      rx_data_out     <= rx_dat_next;
      rx_neg_rail_out <= rx_neg_next;
      rx_violation    <= rx_lcv_next;
      tx_frame_marker_or_data_enable <= marker_next;
    end
  end

  // axi write: address and data caught in either order, response after both
  wire logic aw_take = s_axi_awvalid && s_axi_awready;
  wire logic w_take  = s_axi_wvalid && s_axi_wready;
  wire logic aw_have = aw_held_reg || aw_take;
  wire logic w_have  = w_held_reg || w_take;
  wire logic wr_go   = aw_have && w_have && !s_axi_bvalid;
  wire logic [7:0]  wr_addr = aw_held_reg ? aw_addr_reg : s_axi_awaddr;
  wire logic [31:0] wr_data = w_held_reg ? w_data_reg : s_axi_wdata;
  wire logic [3:0]  wr_strb = w_held_reg ? w_strb_reg : s_axi_wstrb;
  wire logic [31:0] wr_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}},
                               {8{wr_strb[1]}}, {8{wr_strb[0]}}};
  wire logic wr_ctrl = wr_go && (wr_addr == lfms_pkg::ADDR_CTRL);
  wire logic wr_scan = wr_go && (wr_addr == lfms_pkg::ADDR_SCAN);
  wire logic wr_hit  = wr_ctrl || wr_scan || (wr_addr == lfms_pkg::ADDR_STATUS);
  wire logic [31:0] ctrl_next = ((ctrl_reg & ~wr_mask) | (wr_data & wr_mask))
                                & lfms_pkg::CTRL_MASK;
  wire logic [31:0] scan_next = ((scan_reg & ~wr_mask) | (wr_data & wr_mask))
                                & lfms_pkg::SCAN_MASK;

  // registers stay writable whatever mode is decoded
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_reg      <= lfms_pkg::CTRL_RESET;
      scan_reg      <= lfms_pkg::SCAN_RESET;
      aw_held_reg   <= 1'b0;
      w_held_reg    <= 1'b0;
      aw_addr_reg   <= 8'h00;
      w_data_reg    <= 32'h0000_0000;
      w_strb_reg    <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= lfms_pkg::RESP_OKAY;
    end
    else if (ce)
    begin
      if (aw_take)
        aw_addr_reg <= s_axi_awaddr;
      if (w_take)
      begin
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      aw_held_reg   <= aw_have && !wr_go;
      w_held_reg    <= w_have && !wr_go;
      s_axi_awready <= !aw_have && !s_axi_bvalid && !wr_go;
      s_axi_wready  <= !w_have && !s_axi_bvalid && !wr_go;
      if (wr_ctrl)
        ctrl_reg <= ctrl_next;                                       // [RL11]
      if (wr_scan)
        scan_reg <= scan_next;
      if (wr_go)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? lfms_pkg::RESP_OKAY : lfms_pkg::RESP_DECERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // axi read: one outstanding, answer registered on the same edge that takes the address
  wire logic rd_take = s_axi_arvalid && s_axi_arready;
  // pins at 19:16, scan flag at 15, mode packed from bit 0 with spare bits above
  wire logic [31:0] status_word = {12'h000, pin_lvl, scan_on,
                                   {(15 - lfms_pkg::MODE_W){1'b0}}, mode};
  wire logic [31:0] rd_word =
    (s_axi_araddr == lfms_pkg::ADDR_CTRL)   ? ctrl_reg :
    (s_axi_araddr == lfms_pkg::ADDR_STATUS) ? status_word :
    (s_axi_araddr == lfms_pkg::ADDR_SCAN)   ? scan_reg : 32'h0000_0000;
  wire logic rd_hit = (s_axi_araddr == lfms_pkg::ADDR_CTRL) ||
                      (s_axi_araddr == lfms_pkg::ADDR_STATUS) ||
                      (s_axi_araddr == lfms_pkg::ADDR_SCAN);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= lfms_pkg::RESP_OKAY;
    end
    else if (ce)
    begin
      s_axi_arready <= !s_axi_rvalid && !rd_take;
      if (rd_take)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_hit ? lfms_pkg::RESP_OKAY : lfms_pkg::RESP_DECERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: tb/lfms_liu_model.sv
`timescale 1ns/100ps
`default_nettype none
module lfms_liu_model (
  input  wire logic       aclk,      // line clock
  input  wire logic       unipolar,  // far end set for data plus violation
  input  wire logic       violation, // far end flags a code violation
  input  wire logic [3:0] pin_out,   // device pad values
  input  wire logic [3:0] pin_oe,    // device pad enables
  output logic      [3:0] pin_level  // resolved pad levels
);
  logic [3:0] far_drive;
  logic [3:0] last_level = 4'h0;
  // receive pads loop the transmit pads back to the device, except pad 3 carries violation when unipolar
  assign far_drive[2] = pin_level[0];
  assign far_drive[3] = unipolar ? violation : pin_level[1];
  // a released pad must not keep its old level, so show its inverse
  assign far_drive[1:0] = ~last_level[1:0];
  assign pin_level = (pin_oe & pin_out) | (~pin_oe & far_drive);
  // remember levels to model floating pads
  always_ff @(posedge aclk)
    last_level <= pin_level;
endmodule
`default_nettype wire

// file: tb/lfms_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module lfms_checker (
  input wire logic                    aclk,          // clock
  input wire logic                    aresetn,       // sync reset, low
  input wire logic                    ce,            // clock enable
  input wire logic                    s_axi_bvalid,  // write resp valid
  input wire logic                    s_axi_bready,  // write resp ready
  input wire logic                    s_axi_rvalid,  // read valid
  input wire logic                    s_axi_rready,  // read ready
  input wire logic [31:0]             s_axi_rdata,   // read data
  input wire logic                    scan_mode_pin, // scan request
  input wire logic                    tx_sof_in,     // framer frame start
  input wire logic                    tx_den_in,     // framer data enable
  input wire logic                    tx_frame_marker_or_data_enable, // marker pin
  input wire logic [3:0]              line_pin_oe,   // pad enables
  input wire lfms_pkg::lfms_mode_type mode           // decoded mode
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // bus answers stand until taken
  AST_WRESP_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  AST_RDATA_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer changed before taken");
  // decode consistency
  AST_RSVD_IDLE: assert property (mode.reserved |-> mode.cfg_err && !mode.framer_on && !mode.unframed)
    else $error("reserved frame code not idle");
  AST_FRAME_KIND: assert property (mode.framer_on |-> !mode.unframed && !mode.reserved)
    else $error("framed and unframed together");
  AST_CODE_RATE: assert property (mode.unframed && mode.rails_on |-> mode.hdb3 == mode.is_e3)
    else $error("line code does not follow frame code");
  AST_UNI_ZS: assert property (mode.unipolar |-> !mode.tx_ami && !mode.rx_ami && !mode.rails_on)
    else $error("unipolar mode uses zero suppress bits");
  AST_RAIL_LIU: assert property (mode.rails_on |-> !mode.liu_on && !mode.unipolar)
    else $error("rail mode with line interface on");
  // marker follows its source one edge later; sources equal, so either option
  AST_MARKER_SRC: assert property (ce && $stable(mode) && !mode.cfg_err
    && (mode.rails_on || mode.unipolar) && tx_sof_in == tx_den_in
    |=> !$stable(mode) || tx_frame_marker_or_data_enable == $past(tx_sof_in))
    else $error("marker pin not from framer");
  // no line path and no scan: every pad stays released
  AST_IDLE_PADS: assert property ((!scan_mode_pin)[*8] ##0 $stable(mode)
    && (mode.cfg_err || !(mode.rails_on || mode.unipolar)) |-> line_pin_oe == 4'h0)
    else $error("pads driven without a line path");
endmodule
`default_nettype wire

// file: tb/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic aclk, aresetn, ce, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, scan_mode_pin;
  logic tx_data_in, tx_neg_in, tx_sof_in, tx_den_in, tx_frame_marker_or_data_enable;
  logic rx_data_out, rx_neg_rail_out, rx_violation, rsv, uni, viol;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs, zs;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb, line_pin_in, line_pin_out, line_pin_oe;
  logic [2:0] fm, lm;
  logic [13:0] exp_v, msk, got_v;
  lfms_pkg::lfms_mode_type mode;
  int errors, comparisons;
  lfms_top lfms_top_inst (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .scan_mode_pin, .line_pin_in, .line_pin_out, .line_pin_oe,
    .tx_data_in, .tx_neg_in, .tx_sof_in, .tx_den_in, .tx_frame_marker_or_data_enable,
    .rx_data_out, .rx_neg_rail_out, .rx_violation, .mode);
  lfms_liu_model lfms_liu_model_inst (.aclk, .unipolar(uni), .violation(viol),
    .pin_out(line_pin_out), .pin_oe(line_pin_oe), .pin_level(line_pin_in));
  // free running 50 MHz clock
  initial
  begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // each bus task starts one edge on, so no signal is driven twice in a step
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_read(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic complete_run;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // watchdog: the whole run needs under 5000 cycles
  initial
  begin
    repeat (20000) @(posedge aclk);
    errors++;
    complete_run();
  end
  // main sequence
  initial
  begin
    {aresetn, ce, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 7'h01;
    ce = 1'b1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {scan_mode_pin, tx_data_in, tx_neg_in, tx_sof_in, tx_den_in, uni, viol} = '0;
    aresetn = 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    check("mode after reset", 32'h0000_0000, 32'(mode));
    axi_read(lfms_pkg::ADDR_CTRL);
    check("ctrl reset", lfms_pkg::CTRL_RESET, rd);
    axi_read(lfms_pkg::ADDR_SCAN);
    check("scan reset", lfms_pkg::SCAN_RESET, rd);
    axi_write(lfms_pkg::ADDR_CTRL, 32'hFFFF_FFFF, 4'b0001);
    axi_read(lfms_pkg::ADDR_CTRL);
    check("ctrl low lane", 32'h0000_0077, rd);
    axi_write(lfms_pkg::ADDR_CTRL, 32'hFFFF_FFFF, 4'b1111);
    axi_read(lfms_pkg::ADDR_CTRL);
    check("ctrl mask", lfms_pkg::CTRL_MASK, rd);
    axi_write(8'h0C, 32'h1234_5678, 4'b1111);
    check("unmapped write", 32'(lfms_pkg::RESP_DECERR), 32'(rs));
    axi_read(8'h0C);
    check("unmapped read", {30'h0000_0000, lfms_pkg::RESP_DECERR}, {rd[31:2], rs});
    $display("test registers done");
    // every frame code against rail and unipolar line codes
    for (int f = 0; f < 8; f++)
      for (int l = 0; l < 3; l++)
        for (int z = 0; z < 4; z++)
        begin
          fm = 3'(f);
          lm = (l == 0) ? 3'b000 : ((l == 1) ? 3'b100 : 3'b111);
          zs = 2'(z);
          rsv = (fm == 3'b101) || (fm == 3'b111);
          axi_write(lfms_pkg::ADDR_CTRL, {19'h0_0000, 1'b0, zs[1], 1'b1, zs, 1'b0, lm, 1'b0, fm}, 4'hF);
          repeat (2) @(posedge aclk);
          // reserved codes only promise the idle flags, so the rest is masked on both sides
          msk = rsv ? 14'h3C00 : 14'h3FFF;
          exp_v = msk & {!fm[2] && !rsv, fm[2] && !rsv, rsv, rsv, fm[1:0] & {2{!fm[2]}},
                         fm[1], fm[1], lm == 3'b000, lm[2], lm == 3'b000 && zs[0],
                         lm == 3'b000 && zs[1], 1'b0, fm[2] && !rsv && zs[1]};
          got_v = msk & {mode.framer_on, mode.unframed, mode.reserved, mode.cfg_err,
                         mode.fmt & {2{!fm[2]}}, mode.is_e3, mode.hdb3, mode.rails_on,
                         mode.unipolar, mode.tx_ami, mode.rx_ami, mode.liu_on, mode.clock_rate_adapter_tx};
          check("frame decode", 32'(exp_v[13:8]), 32'(got_v[13:8]));
          check("line decode", 32'(exp_v[7:0]), 32'(got_v[7:0]));
        end
    axi_write(lfms_pkg::ADDR_CTRL, 32'h0000_0000, 4'hF);
    repeat (2) @(posedge aclk);
    check("line enable off", 32'h0000_0001, 32'(mode.cfg_err));
    $display("test decode done");
    // marker option and rail path, unframed ds3 over rails
    tx_sof_in <= 1'b1;
    tx_data_in <= 1'b1;
    for (int b = 0; b < 2; b++)
    begin
      axi_write(lfms_pkg::ADDR_CTRL, 32'h0000_0404 | (32'(b) << 12), 4'hF);
      repeat (3) @(posedge aclk);
      check("marker pin", 32'(b == 0), 32'(tx_frame_marker_or_data_enable));
    end
    // both marker sources high so the marker checker sees a one as well
    tx_den_in <= 1'b1;
    check("tx rails", 32'h0000_0031, 32'({line_pin_oe[1:0], 2'b00, line_pin_out[1:0]}));
    repeat (8) @(posedge aclk);
    check("marker data enable", 32'h0000_0001, 32'(tx_frame_marker_or_data_enable));
    check("rx rails low", 32'h0000_0002, 32'({rx_data_out, rx_neg_rail_out}));
    tx_neg_in <= 1'b1;
    repeat (8) @(posedge aclk);
    check("rx rails high", 32'h0000_0003, 32'({rx_data_out, rx_neg_rail_out}));
    uni <= 1'b1;
    viol <= 1'b1;
    axi_write(lfms_pkg::ADDR_CTRL, 32'h0000_0444, 4'hF);
    repeat (8) @(posedge aclk);
    check("unipolar rx", 32'h0000_0003, 32'({rx_data_out, rx_violation}));
    // clock enable low must freeze the transmit pad
    ce <= 1'b0;
    tx_data_in <= 1'b0;
    repeat (4) @(posedge aclk);
    check("ce freeze", 32'h0000_0001, 32'(line_pin_out[0]));
    ce <= 1'b1;
    repeat (2) @(posedge aclk);
    check("ce resume", 32'h0000_0000, 32'(line_pin_out[0]));
    $display("test line path done");
    // boundary scan takes over every pad
    scan_mode_pin <= 1'b1;
    axi_write(lfms_pkg::ADDR_SCAN, 32'h0000_006F, 4'hF);
    repeat (8) @(posedge aclk);
    check("scan pads", 32'h0000_0066, 32'({line_pin_oe, line_pin_out & line_pin_oe}));
    axi_read(lfms_pkg::ADDR_SCAN);
    check("scan readback", 32'h0000_006F, rd);
    // pad 0 floats in scan mode, so its level bit is left out
    axi_read(lfms_pkg::ADDR_STATUS);
    check("status word", 32'h000E_8408, rd & 32'h000E_FFFF);
    $display("test scan done");
    complete_run();
  end
endmodule
bind lfms_top lfms_checker lfms_checker_inst (.aclk, .aresetn, .ce, .s_axi_bvalid, .s_axi_bready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .scan_mode_pin, .tx_sof_in, .tx_den_in,
  .tx_frame_marker_or_data_enable, .line_pin_oe, .mode);
`default_nettype wire
